// [include/scc_pkg.sv]
// package: register map, field layout, reset values and timing counts of the clock control
package scc_pkg;
	// ==========================================
	// register map
	localparam logic [11:0] SCC_ADDR_SYSCTL = 12'h000;
	localparam logic [11:0] SCC_ADDR_STATUS = 12'h004;
	// ==========================================
	// field positions of system_control
	localparam int SCC_BIT_BW = 0;
	localparam int SCC_BIT_COE = 1;
	localparam int SCC_BIT_CSEL = 2;
	localparam int SCC_BIT_STOP = 3;
	localparam int SCC_BIT_RCAUSE = 4;
	localparam int SCC_BIT_SPWR = 5;
	localparam int SCC_BIT_TLO = 6;
	localparam int SCC_BIT_THI = 7;
	// ==========================================
	// reset values
	localparam logic SCC_RST_TONE = 1'b0;
	localparam logic SCC_RST_SPWR = 1'b1;
	localparam logic SCC_RST_CSEL = 1'b0;
	localparam logic SCC_RST_COE = 1'b1;
	localparam logic SCC_RST_BW = 1'b1;
	localparam logic SCC_RST_STOP = 1'b1;
	// ==========================================
	// tone codes and dividers
	localparam logic [1:0] SCC_TONE_OFF = 2'h0;
	localparam logic [1:0] SCC_TONE_D32 = 2'h1;
	localparam logic [1:0] SCC_TONE_D16 = 2'h2;
	localparam int SCC_TONE_TAP_D8 = 2;
	localparam int SCC_TONE_TAP_D16 = 3;
	localparam int SCC_TONE_TAP_D32 = 4;
	// ==========================================
	// watchdog: oscillator periods to time out, tolerance kept in low stages
	localparam int SCC_WDOG_PERIODS = 98296;
	localparam int SCC_WDOG_KEEP_BITS = 4;
	localparam int SCC_WDOG_W = 17;
	// ==========================================
	// pll feedback dividers per supply version
	localparam int SCC_FB_DIV_5V = 64;
	localparam int SCC_FB_DIV_3V = 16;
	// ==========================================
	// carriers
	typedef struct packed {
		logic tone_select_high;
		logic tone_select_low;
		logic synth_power;
		logic osc_stop_second_latch;
		logic clock_source_select;
		logic clock_out_enable;
		logic loop_bandwidth_wide;
	} scc_ctrl_s;
	typedef enum logic [2:0] {
		SCC_SW_OSC = 3'b001,
		SCC_SW_GAP = 3'b010,
		SCC_SW_SYN = 3'b100
	} scc_sw_e;
endpackage

// [hdl/scc_top.sv]
// system clock control register with clock switch, tone, watchdog and pll detector
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - any reset clears both tone select bits
// - tone code 11 gives oscillator divided by eight
// - code 00 floats, 01 div32, 10 div16
// - synth power bit switches synthesizer, set at reset
// - clearing synth power ignored while synthesizer selected
// - reset cause reads watchdog origin, read clears
// - writing one there restarts watchdog count
// - watchdog times out near 98296 periods, resets
// - first write loads latch a, later latch b
// - stop kills oscillator only if both latches zero
// - one means gate only, zero allows kill
// - reads return latch b, one before second write
// - clock select picks synthesizer or oscillator, cleared reset
// - setting clock select ignored while synthesizer off
// - processor clock switches without runt pulses
// - clock output enable drives or holds pin low
// - bandwidth bit wide when one, set at reset
// - feedback divides by 64 or 16 per version
// - phase detector compares feedback against reference
module scc_top
	import scc_pkg::*;
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic osc_i,
	input wire logic vco_i,
	input wire logic stop_i,
	input wire logic low_voltage_i,
	output logic cpu_clk_en_o,
	output logic clock_output_pin_o,
	output logic tone_output_pin_o,
	output logic tone_output_pin_oe_o,
	output logic synth_enable_o,
	output logic loop_bandwidth_wide_o,
	output logic osc_kill_o,
	output logic osc_gate_o,
	output logic phase_up_o,
	output logic phase_down_o,
	output logic wdog_reset_o
);
	// ==========================================
	// synchronisers for the pin inputs
	logic [1:0] osc_sync_reg;
	logic [1:0] vco_sync_reg;
	logic [1:0] stop_sync_reg;
	logic osc_prev_reg;
	logic vco_prev_reg;
	// two flops each; only stage one reads stage zero
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			osc_sync_reg <= 2'h0;
			vco_sync_reg <= 2'h0;
			stop_sync_reg <= 2'h0;
			osc_prev_reg <= 1'b0;
			vco_prev_reg <= 1'b0;
		end else begin
			osc_sync_reg <= {osc_sync_reg[0], osc_i};
			vco_sync_reg <= {vco_sync_reg[0], vco_i};
			stop_sync_reg <= {stop_sync_reg[0], stop_i};
			osc_prev_reg <= osc_sync_reg[1];
			vco_prev_reg <= vco_sync_reg[1];
		end
	end
	// rising edges of oscillator and synthesizer as one-cycle enables
	wire osc_tick = osc_sync_reg[1] & ~osc_prev_reg;
	wire vco_tick = vco_sync_reg[1] & ~vco_prev_reg;
	wire stop_now = stop_sync_reg[1];
	// ==========================================
	// apb decode
	wire setup_ph = psel_i & ~penable_i;
	wire access_ph = psel_i & penable_i;
	wire hit_ctl = paddr_i == SCC_ADDR_SYSCTL;
	wire hit_sts = paddr_i == SCC_ADDR_STATUS;
	wire mapped = hit_ctl | hit_sts;
	// strobe gates the only byte that holds data
	wire wr_ctl = access_ph & pwrite_i & hit_ctl & pstrb_i[0];
	wire rd_ctl = access_ph & ~pwrite_i & hit_ctl;
	wire [7:0] wd = pwdata_i[7:0];
	// ==========================================
	// register state
	scc_ctrl_s ctl_reg;
	scc_ctrl_s ctl_next;
	logic latch_a_reg;
	logic first_done_reg;
	logic rcause_reg;
	logic wdog_fired_reg;
	// interlocks look at the contents held before this write
	always_comb begin
		ctl_next = ctl_reg;
		if (wr_ctl) begin
			ctl_next.tone_select_high = wd[SCC_BIT_THI];
			ctl_next.tone_select_low = wd[SCC_BIT_TLO];
			// selected synthesizer cannot be turned off
			ctl_next.synth_power = wd[SCC_BIT_SPWR] | ctl_reg.clock_source_select;
			// a synthesizer that is off cannot be selected
			ctl_next.clock_source_select = wd[SCC_BIT_CSEL] & ctl_reg.synth_power;
			ctl_next.clock_out_enable = wd[SCC_BIT_COE];
			ctl_next.loop_bandwidth_wide = wd[SCC_BIT_BW];
			// later writes reach only latch b
			if (first_done_reg) begin
				ctl_next.osc_stop_second_latch = wd[SCC_BIT_STOP];
			end
		end
	end
	// control register; reset state is the documented one
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctl_reg <= '{SCC_RST_TONE, SCC_RST_TONE, SCC_RST_SPWR, SCC_RST_STOP,
				SCC_RST_CSEL, SCC_RST_COE, SCC_RST_BW};
		end else if (wdog_fired_reg) begin
			ctl_reg <= '{SCC_RST_TONE, SCC_RST_TONE, SCC_RST_SPWR, SCC_RST_STOP,
				SCC_RST_CSEL, SCC_RST_COE, SCC_RST_BW};
		end else begin
			ctl_reg <= ctl_next;
		end
	end
	// latch a takes only the first write after any reset
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			latch_a_reg <= SCC_RST_STOP;
			first_done_reg <= 1'b0;
		end else if (wdog_fired_reg) begin
			latch_a_reg <= SCC_RST_STOP;
			first_done_reg <= 1'b0;
		end else if (wr_ctl && !first_done_reg) begin
			latch_a_reg <= wd[SCC_BIT_STOP];
			first_done_reg <= 1'b1;
		end
	end
	// reset cause: set by watchdog reset, cleared by a read; set wins
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rcause_reg <= 1'b0;
		end else if (wdog_fired_reg) begin
			rcause_reg <= 1'b1;
		end else if (rd_ctl) begin
			rcause_reg <= 1'b0;
		end
	end
	// ==========================================
	// watchdog counts oscillator periods
	logic [SCC_WDOG_W-1:0] wdog_cnt_reg;
	localparam logic [SCC_WDOG_W-1:0] WDOG_LAST = SCC_WDOG_W'(SCC_WDOG_PERIODS - 1);
	// low stages are kept on restart and on time out, so the time out varies by their span
	wire wdog_clear = wr_ctl & wd[SCC_BIT_RCAUSE];
	wire wdog_hit = osc_tick & (wdog_cnt_reg >= WDOG_LAST);
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wdog_cnt_reg <= '0;
			wdog_fired_reg <= 1'b0;
		end else begin
			wdog_fired_reg <= wdog_hit;
			if (wdog_clear || wdog_fired_reg) begin
				wdog_cnt_reg <= {{(SCC_WDOG_W-SCC_WDOG_KEEP_BITS){1'b0}},
					wdog_cnt_reg[SCC_WDOG_KEEP_BITS-1:0]};
			end else if (osc_tick) begin
				wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
			end
		end
	end
	// ==========================================
	// tone divider on oscillator ticks
	logic [4:0] tone_div_reg;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tone_div_reg <= '0;
		end else if (osc_tick) begin
			tone_div_reg <= tone_div_reg + 1'b1;
		end
	end
	wire [1:0] tone_code = {ctl_reg.tone_select_high, ctl_reg.tone_select_low};
	// taps: bit2 = /8, bit3 = /16, bit4 = /32
	wire tone_level = (tone_code == SCC_TONE_D32) ? tone_div_reg[SCC_TONE_TAP_D32] :
		(tone_code == SCC_TONE_D16) ? tone_div_reg[SCC_TONE_TAP_D16] :
		tone_div_reg[SCC_TONE_TAP_D8];
	wire tone_drive = tone_code != SCC_TONE_OFF;
	// ==========================================
	// glitch-free switch: old source stops on its own rising edge, then new one starts on its own
	scc_sw_e sw_reg;
	scc_sw_e sw_next;
	wire want_syn = ctl_reg.clock_source_select & ctl_reg.synth_power;
	always_comb begin
		case (sw_reg)
			SCC_SW_OSC: sw_next = (want_syn && osc_tick) ? SCC_SW_GAP : SCC_SW_OSC;
			SCC_SW_SYN: sw_next = (!want_syn && vco_tick) ? SCC_SW_GAP : SCC_SW_SYN;
			SCC_SW_GAP: begin
				// enter a source only on its own edge so no runt cycle escapes
				if (want_syn) begin
					sw_next = vco_tick ? SCC_SW_SYN : SCC_SW_GAP;
				end else begin
					sw_next = osc_tick ? SCC_SW_OSC : SCC_SW_GAP;
				end
			end
			default: sw_next = SCC_SW_OSC;
		endcase
	end
	wire src_tick = (sw_reg == SCC_SW_OSC) ? osc_tick :
		(sw_reg == SCC_SW_SYN) ? vco_tick : 1'b0;
	// oscillator gated off during stop; killed only if both latches zero
	wire kill = stop_now & ~latch_a_reg & ~ctl_reg.osc_stop_second_latch;
	// ==========================================
	// pll feedback divider and phase detector
	logic [5:0] fb_div_reg;
	logic fb_tick_reg;
	wire [5:0] fb_last = low_voltage_i ? 6'(SCC_FB_DIV_3V - 1) : 6'(SCC_FB_DIV_5V - 1);
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fb_div_reg <= '0;
			fb_tick_reg <= 1'b0;
		end else begin
			fb_tick_reg <= vco_tick && (fb_div_reg >= fb_last);
			if (vco_tick) begin
				fb_div_reg <= (fb_div_reg >= fb_last) ? 6'h00 : fb_div_reg + 6'h01;
			end
		end
	end
	// tri-state style phase-frequency detector
	logic up_reg;
	logic dn_reg;
	wire up_n = (up_reg | osc_tick) & ~(dn_reg | fb_tick_reg);
	wire dn_n = (dn_reg | fb_tick_reg) & ~(up_reg | osc_tick);
	// ==========================================
	// read data and output flops
	wire [7:0] rd_byte = {ctl_reg.tone_select_high, ctl_reg.tone_select_low,
		ctl_reg.synth_power, rcause_reg, ctl_reg.osc_stop_second_latch,
		ctl_reg.clock_source_select, ctl_reg.clock_out_enable, ctl_reg.loop_bandwidth_wide};
	wire [31:0] rd_word = hit_ctl ? {24'h000000, rd_byte} :
		hit_sts ? {27'h0000000, latch_a_reg, first_done_reg, sw_reg} : 32'h00000000;
	// zero-wait slave: ready the cycle after setup, errors on unmapped
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sw_reg <= SCC_SW_OSC;
			up_reg <= 1'b0;
			dn_reg <= 1'b0;
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			cpu_clk_en_o <= 1'b0;
			clock_output_pin_o <= 1'b0;
			tone_output_pin_o <= 1'b0;
			tone_output_pin_oe_o <= 1'b0;
			synth_enable_o <= SCC_RST_SPWR;
			loop_bandwidth_wide_o <= SCC_RST_BW;
			osc_kill_o <= 1'b0;
			osc_gate_o <= 1'b0;
			phase_up_o <= 1'b0;
			phase_down_o <= 1'b0;
			wdog_reset_o <= 1'b0;
		end else begin
			sw_reg <= sw_next;
			up_reg <= up_n;
			dn_reg <= dn_n;
			pready_o <= setup_ph;
			pslverr_o <= setup_ph & ~mapped;
			prdata_o <= (setup_ph && !pwrite_i) ? rd_word : 32'h00000000;
			cpu_clk_en_o <= src_tick & ~stop_now;
			clock_output_pin_o <= ctl_reg.clock_out_enable & src_tick & ~stop_now;
			tone_output_pin_o <= tone_drive & tone_level;
			tone_output_pin_oe_o <= tone_drive;
			synth_enable_o <= ctl_reg.synth_power;
			loop_bandwidth_wide_o <= ctl_reg.loop_bandwidth_wide;
			osc_kill_o <= kill;
			osc_gate_o <= stop_now & ~kill;
			phase_up_o <= up_n;
			phase_down_o <= dn_n;
			wdog_reset_o <= wdog_fired_reg;
		end
	end
endmodule // scc_top

// [sim/scc_monitor.sv]
// checker: port-level relations of the clock control block
`timescale 1ns/1ps
module scc_monitor
	import scc_pkg::*;
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic cpu_clk_en_o,
	input wire logic clock_output_pin_o,
	input wire logic osc_kill_o,
	input wire logic osc_gate_o,
	input wire logic wdog_reset_o
);
	// ==========================================
	// decode of the two mapped words
	wire mapped;
	assign mapped = (paddr_i == SCC_ADDR_SYSCTL) || (paddr_i == SCC_ADDR_STATUS);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// ==========================================
	// bus, stop, clock and watchdog relations
	a_setup_gets_ready: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	a_err_on_unmapped: assert property (psel_i && !penable_i && !mapped |=> pslverr_o)
		else $error("unmapped access not refused");
	a_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_rdata_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside access");
	a_upper_bits_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_kill_gate_excl: assert property (!(osc_kill_o && osc_gate_o))
		else $error("kill and gate together");
	a_clkout_needs_clk: assert property (!cpu_clk_en_o |-> !clock_output_pin_o)
		else $error("clock out without processor clock");
	a_clk_no_runt: assert property (cpu_clk_en_o |=> !cpu_clk_en_o)
		else $error("processor clock runt");
	a_wdog_one_pulse: assert property (wdog_reset_o |=> !wdog_reset_o)
		else $error("watchdog pulse too long");
endmodule // scc_monitor

bind scc_top scc_monitor scc_monitor_inst (.clock_i(clock_i), .resetn_i(resetn_i),
	.psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_clk_en_o(cpu_clk_en_o),
	.clock_output_pin_o(clock_output_pin_o), .osc_kill_o(osc_kill_o),
	.osc_gate_o(osc_gate_o), .wdog_reset_o(wdog_reset_o));

// [sim/system_clock_control_register_test.sv]
// testbench: register, interlock, stop, tone and bus checks
`timescale 1ns/1ps
module system_clock_control_register_test
	import scc_pkg::*;
;
	logic clock_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic osc_i = 0, vco_i = 0, stop_i = 0, low_voltage_i = 0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic [3:0] pstrb_i = 4'hf;
	logic [2:0] vc = 3'h0; // oscillator and vco dividers
	logic pready_o, pslverr_o, cpu_clk_en_o, clock_output_pin_o, tone_output_pin_o;
	logic tone_output_pin_oe_o, synth_enable_o, loop_bandwidth_wide_o, osc_kill_o;
	logic osc_gate_o, phase_up_o, phase_down_o, wdog_reset_o;
	logic [33:0] notes[$]; // {check data, error, data}
	logic [33:0] nt;
	int bad_count = 0, n_checks = 0, seed = 32'hd221, i, p;
	scc_top scc_top_inst (.*);
	initial forever #5 clock_i = ~clock_i;
	// osc period 4 clocks, vco period 8: keeps rising edges apart
	always @(posedge clock_i) begin
		vc <= vc + 3'h1;
		osc_i <= vc[1];
		vco_i <= vc[2];
	end
	// ==========================================
	// result watcher takes the oldest note
	always @(posedge clock_i) if (psel_i && penable_i && pready_o === 1'b1) begin
		nt = notes.pop_front();
		n_checks++;
		if (pslverr_o !== nt[32] || (nt[33] && prdata_o !== nt[31:0])) begin
			bad_count++;
			$display("[ERR] %0t bus result %h", $time, prdata_o);
		end
	end
	task automatic tally_and_finish;
		if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t pin mismatch", $time);
		end
	endtask
	// one transfer, held until ready, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [33:0] n);
		int k;
		notes.push_back(n);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clock_i);
			k++;
		end while (pready_o !== 1'b1 && k < 20);
		if (k >= 20) begin
			bad_count++;
			tally_and_finish();
		end
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic w0(input logic [7:0] d);
		apb(1'b1, SCC_ADDR_SYSCTL, {24'h0, d}, 34'h0);
	endtask
	task automatic r0(input logic [7:0] v);
		apb(1'b0, SCC_ADDR_SYSCTL, 32'h0, {2'b10, 24'h0, v});
	endtask
	// stop request: kill or gate expected
	task automatic stopchk(input logic kill);
		int k;
		stop_i <= 1'b1;
		for (k = 0; k < 10 && osc_kill_o !== 1'b1 && osc_gate_o !== 1'b1; k++)
			@(posedge clock_i);
		chk(osc_kill_o, kill);
		chk(osc_gate_o, !kill);
		// processor clock must stay quiet for the 8 cycles that stop is held after kill or gate shows
		repeat (8) begin
			@(posedge clock_i);
			chk(cpu_clk_en_o, 1'b0);
		end
		stop_i <= 1'b0;
		repeat (6) @(posedge clock_i);
	endtask
	// counts clock output pulses, or tone period when t is set
	task automatic count(input logic t, output int c);
		logic prev;
		int k, e;
		c = 0;
		e = 0;
		// let the last write reach the registered pin before taking a reference level
		@(posedge clock_i);
		prev = tone_output_pin_o;
		for (k = 0; k < 600 && e < 2; k++) begin
			@(posedge clock_i);
			if (!t && k < 40 && clock_output_pin_o === 1'b1) c++;
			if (t && e == 1) c++;
			if (t && tone_output_pin_o === 1'b1 && prev === 1'b0) e++;
			prev = tone_output_pin_o;
		end
	endtask
	// cycles between two drops of phase_up_o; each drop follows a feedback tick
	// the first drop is skipped, since a divider change leaves one odd interval
	task automatic fbper(output int c);
		logic prev;
		int k, e;
		c = 0;
		e = 0;
		prev = phase_up_o;
		for (k = 0; k < 1600 && e < 3; k++) begin
			@(posedge clock_i);
			if (e == 2) c++;
			if (phase_up_o === 1'b0 && prev === 1'b1) e++;
			prev = phase_up_o;
		end
	endtask
	initial begin
		repeat (8) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		chk(tone_output_pin_oe_o, 1'b0);
		r0(8'h2b);
		w0(8'h23);
		r0(8'h2b);
		w0(8'h33);
		r0(8'h23);
		stopchk(1'b1);
		w0(8'h2b);
		stopchk(1'b0);
		w0(8'h2f);
		w0(8'h0f);
		r0(8'h2f);
		w0(8'h0b);
		r0(8'h2b);
		w0(8'h0a);
		r0(8'h0a);
		chk(synth_enable_o, 1'b0);
		chk(loop_bandwidth_wide_o, 1'b0);
		w0(8'h0f);
		r0(8'h0b);
		w0(8'h2b);
		pstrb_i <= 4'he;
		w0(8'h00);
		pstrb_i <= 4'hf;
		r0(8'h2b);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, 12'h008 + 12'(4 * ({$random(seed)} % 500)), $random(seed), 34'h100000000);
			apb(1'b0, 12'h008 + 12'(4 * ({$random(seed)} % 500)), 32'h0, 34'h300000000);
		end
		count(1'b0, p);
		chk(p > 0, 1'b1);
		w0(8'h29);
		count(1'b0, p);
		chk(p == 0, 1'b1);
		for (i = 1; i < 4; i++) begin
			w0({i[1:0], 6'h2b});
			count(1'b1, p);
			chk(tone_output_pin_oe_o, 1'b1);
			chk(p == (256 >> i), 1'b1);
		end
		// feedback period is the divider times the vco period of 8 clocks
		fbper(p);
		chk(p == SCC_FB_DIV_5V * 8, 1'b1);
		low_voltage_i <= 1'b1;
		fbper(p);
		chk(p == SCC_FB_DIV_3V * 8, 1'b1);
		chk(phase_down_o, 1'b0);
		for (i = 0; i < 20 && notes.size() > 0; i++) @(posedge clock_i);
		if (notes.size() > 0) bad_count++;
		tally_and_finish();
	end
endmodule // system_clock_control_register_test
